/* File: rtl/sew_pkg.sv */
// Shared constants and types for the streamer event wait block
package sew_pkg;

    // ==========================================================
    // Instruction encoding
    // ==========================================================
    localparam logic [6:0] SEW_OPC_EVT  = 7'h6B;
    localparam logic [8:0] SEW_SRC_EVT  = 9'h024;
    localparam logic [8:0] SEW_DST_SLOT = 9'h01A;
    localparam logic [8:0] SEW_DST_LUT  = 9'h01D;
    localparam logic [8:0] SEW_DST_OSC  = 9'h01C;
    localparam logic [8:0] SEW_LUT_LAST = 9'h1FF;

    // ==========================================================
    // Flag positions
    // ==========================================================
    localparam int SEW_F_SLOT = 0;
    localparam int SEW_F_LUT  = 1;
    localparam int SEW_F_OSC  = 2;
    localparam int SEW_NFLAG  = 3;

    // ==========================================================
    // Register map
    // ==========================================================
    localparam logic [3:0] SEW_A_CTRL  = 4'h0;
    localparam logic [3:0] SEW_A_FLAGS = 4'h4;
    localparam logic [3:0] SEW_A_TGT   = 4'h8;
    localparam int         SEW_CTRL_TMO = 0;
    localparam logic       SEW_CTRL_RST = 1'b1;
    localparam int         SEW_ST_BUSY  = 3;
    localparam logic [1:0] SEW_OKAY     = 2'h0;
    localparam logic [1:0] SEW_SLVERR   = 2'h2;

    // ==========================================================
    // Types
    // ==========================================================
    typedef struct packed {
        logic [3:0] cond;
        logic [6:0] opcode;
        logic       c;
        logic       z;
        logic       i;
        logic [8:0] dest;
        logic [8:0] src;
    } sew_instr_t;

    typedef struct packed {
        logic       stream_cmd;
        logic [2:0] poll;
    } sew_clr_t;

    typedef struct packed {
        logic c_we;
        logic c_val;
        logic z_we;
        logic z_val;
    } sew_fx_t;

    typedef enum logic [1:0] {
        SEW_IDLE = 2'b01,
        SEW_WAIT = 2'b10
    } sew_state_t;

endpackage

/* File: rtl/sew_core.sv */
// Streamer event flags and wait-instruction stall logic
// Behaviour
// - Wait ends at once if flag set, else on event; clears flag, set wins
// - Queue load just before wait arms timeout; counter hit aborts the wait
// - Requested carry/zero written only when timeout armed: 1 on timeout alone, 0 on event or on both in one cycle
// - Pipeline stalled, no issue, no interrupt, until wait ends
// - Slot-free flag set when streamer becomes ready for a command
// - Slot-free flag cleared by stream commands and its poll/wait/jumps
// - Lookup-wrap flag set when streamer reads lookup location 1FF
// - Lookup-wrap flag cleared at core start and by its poll/wait/jumps
// - Oscillator-wrap flag set each time the streamer oscillator wraps
// - Oscillator-wrap flag cleared by stream commands and its poll/wait/jumps
// - Lookup-wrap wait is event opcode, dest 000011101, src 000100100
// - Oscillator-wrap wait is event opcode, dest 000011100, same src
// - Slot-free wait is event opcode, dest 000011010, same src
module sew_core
    import sew_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [3:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [3:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic        issue_valid,
    input  sew_instr_t       issue_instr,
    input  wire logic        qload_valid,
    input  wire logic [31:0] qload_value,
    input  sew_clr_t         clr_req,
    input  wire logic        core_start,
    input  wire logic        slot_ready,
    input  wire logic        lut_rd,
    input  wire logic [8:0]  lut_addr,
    input  wire logic        osc_wrap,
    input  wire logic [31:0] sys_cnt,
    output logic             stall,
    output logic             wait_done,
    output sew_fx_t          flag_fx,
    output logic [2:0]       flags
);

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ==========================================================
    // Declarations
    // ==========================================================
    sew_state_t  state_reg;
    logic        stall_reg;
    logic        done_reg;
    sew_fx_t     fx_reg;
    logic        issue_ok;
    logic [2:0]  wsel;
    logic [2:0]  wsel_reg;
    logic        fxc_reg;
    logic        fxz_reg;
    logic        arm_reg;
    logic        qprev_reg;
    logic [31:0] target_reg;
    logic        wait_hit;
    logic        wait_tmo;
    logic        wait_end;
    logic [2:0]  flag_reg;
    logic [2:0]  set_vec;
    logic [2:0]  clr_vec;
    logic [2:0]  src_clr;
    logic [2:0]  sw_clr;
    logic [2:0]  wait_clr;
    logic        cmd_clr;
    logic        slot_prev_reg;
    logic        ctrl_tmo_reg;
    logic        aw_have_reg;
    logic        w_have_reg;
    logic [3:0]  awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        awready_reg;
    logic        wready_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic        arready_reg;
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;
    logic        wr_fire;

    // ==========================================================
    // Decoding
    // ==========================================================

    // Map a wait instruction onto its flag
    function automatic logic [2:0] wait_sel(input sew_instr_t ins);
        logic [2:0] sel;
        sel = 3'h0;
        if (ins.opcode == SEW_OPC_EVT && ins.src == SEW_SRC_EVT) begin
            if (ins.dest == SEW_DST_SLOT) sel[SEW_F_SLOT] = 1'b1;
            if (ins.dest == SEW_DST_LUT) sel[SEW_F_LUT] = 1'b1;
            if (ins.dest == SEW_DST_OSC) sel[SEW_F_OSC] = 1'b1;
        end
        return sel;
    endfunction

    // Register address is mapped
    function automatic logic addr_ok(input logic [3:0] a);
        return a == SEW_A_CTRL || a == SEW_A_FLAGS || a == SEW_A_TGT;
    endfunction

    // Issue only while not stalled
    assign issue_ok = issue_valid & ~stall_reg;
    assign wsel     = issue_ok ? wait_sel(issue_instr) : 3'h0;

    lut_decode_a: assert property (
        issue_ok && issue_instr.opcode == SEW_OPC_EVT
        && issue_instr.src == SEW_SRC_EVT
        && issue_instr.dest == SEW_DST_LUT
        |=> stall_reg && wsel_reg == 3'b010)
        else $error("lookup wait not decoded");

    // ==========================================================
    // Event flags
    // ==========================================================

    // Edge of streamer readiness
    always_ff @(posedge aclk) begin
        if (!aresetn) slot_prev_reg <= 1'b0;
        else slot_prev_reg <= slot_ready;
    end

    // Flag set sources
    assign set_vec[SEW_F_SLOT] = slot_ready & ~slot_prev_reg;
    assign set_vec[SEW_F_LUT]  = lut_rd & (lut_addr == SEW_LUT_LAST);
    assign set_vec[SEW_F_OSC]  = osc_wrap;

    // Flag clear sources
    assign cmd_clr             = issue_ok & clr_req.stream_cmd;
    assign src_clr[SEW_F_SLOT] = cmd_clr;
    assign src_clr[SEW_F_LUT]  = core_start;
    assign src_clr[SEW_F_OSC]  = cmd_clr;
    assign wait_clr            = wait_hit ? wsel_reg : 3'h0;
    assign clr_vec = src_clr | sw_clr | wait_clr
                   | (issue_ok ? clr_req.poll : 3'h0);

    // Sticky flags, a set beats a clear
    for (genvar g = 0; g < SEW_NFLAG; g++) begin : g_flag
        always_ff @(posedge aclk) begin
            if (!aresetn) flag_reg[g] <= 1'b0;
            else flag_reg[g] <= set_vec[g] | (flag_reg[g] & ~clr_vec[g]);
        end
    end

    slot_set_a: assert property (
        slot_ready && !slot_prev_reg |=> flag_reg[SEW_F_SLOT])
        else $error("slot flag not set");

    lut_set_a: assert property (
        lut_rd && lut_addr == SEW_LUT_LAST |=> flag_reg[SEW_F_LUT])
        else $error("lookup flag not set");

    osc_set_a: assert property (
        osc_wrap |=> flag_reg[SEW_F_OSC])
        else $error("oscillator flag not set");

    cmd_clear_a: assert property (
        cmd_clr && !set_vec[SEW_F_SLOT] && !set_vec[SEW_F_OSC]
        |=> !flag_reg[SEW_F_SLOT] && !flag_reg[SEW_F_OSC])
        else $error("stream command left flag set");

    start_clear_a: assert property (
        core_start && !set_vec[SEW_F_LUT] |=> !flag_reg[SEW_F_LUT])
        else $error("core start left lookup flag set");

    // ==========================================================
    // Wait sequencing
    // ==========================================================

    // End conditions of a wait in progress
    assign wait_hit = state_reg == SEW_WAIT && |(wsel_reg & flag_reg);
    assign wait_tmo = state_reg == SEW_WAIT && arm_reg
                    && sys_cnt == target_reg;
    assign wait_end = wait_hit | wait_tmo;

    // Queue load immediately before a wait
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            qprev_reg  <= 1'b0;
            target_reg <= 32'h0000_0000;
        end else if (issue_ok) begin
            qprev_reg <= qload_valid;
            if (qload_valid) target_reg <= qload_value;
        end
    end

    // Wait context captured at issue
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wsel_reg <= 3'h0;
            fxc_reg  <= 1'b0;
            fxz_reg  <= 1'b0;
            arm_reg  <= 1'b0;
        end else if (|wsel) begin
            wsel_reg <= wsel;
            fxc_reg  <= issue_instr.c;
            fxz_reg  <= issue_instr.z;
            arm_reg  <= qprev_reg & ctrl_tmo_reg;
        end
    end

    // Stall state machine
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= SEW_IDLE;
            stall_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                SEW_IDLE: begin
                    if (|wsel) begin
                        state_reg <= SEW_WAIT;
                        stall_reg <= 1'b1;
                    end
                end
                SEW_WAIT: begin
                    if (wait_end) begin
                        state_reg <= SEW_IDLE;
                        stall_reg <= 1'b0;
                    end
                end
                default: begin
                    state_reg <= SEW_IDLE;
                    stall_reg <= 1'b0;
                end
            endcase
        end
    end

    // Completion pulse and flag effects
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_reg <= 1'b0;
            fx_reg   <= '0;
        end else begin
            done_reg     <= wait_end;
            fx_reg.c_we  <= wait_end & fxc_reg & arm_reg;
            fx_reg.z_we  <= wait_end & fxz_reg & arm_reg;
            fx_reg.c_val <= wait_tmo & ~wait_hit;
            fx_reg.z_val <= wait_tmo & ~wait_hit;
        end
    end

    assign stall     = stall_reg;
    assign wait_done = done_reg;
    assign flag_fx   = fx_reg;
    assign flags     = flag_reg;

    quick_done_a: assert property (
        issue_ok && |(wait_sel(issue_instr) & flag_reg & ~clr_vec)
        |=> ##1 done_reg && !stall_reg)
        else $error("set flag did not end wait in two clocks");

    flag_clear_a: assert property (
        wait_hit && !(|(wsel_reg & set_vec))
        |=> (flag_reg & $past(wsel_reg)) == 3'h0)
        else $error("wait left its flag set");

    tmo_abort_a: assert property (
        state_reg == SEW_WAIT && arm_reg && sys_cnt == target_reg
        |=> !stall_reg && done_reg)
        else $error("timeout did not abort wait");

    fx_value_a: assert property (
        done_reg && fx_reg.c_we |-> fx_reg.c_val == !$past(wait_hit))
        else $error("carry effect has wrong value");

    stall_hold_a: assert property (
        stall_reg && !wait_end |=> stall_reg && !done_reg)
        else $error("stall dropped without wait end");

    no_tmo_fx_a: assert property (
        done_reg && !arm_reg |-> !fx_reg.c_we && !fx_reg.z_we)
        else $error("flag effect without timeout");

    // ==========================================================
    // Register bus
    // ==========================================================

    // Write address channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b1;
            aw_have_reg <= 1'b0;
            awaddr_reg  <= 4'h0;
        end else if (awvalid && awready_reg) begin
            awready_reg <= 1'b0;
            aw_have_reg <= 1'b1;
            awaddr_reg  <= awaddr;
        end else if (bvalid_reg && bready) begin
            awready_reg <= 1'b1;
            aw_have_reg <= 1'b0;
        end
    end

    // Write data channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_reg <= 1'b1;
            w_have_reg <= 1'b0;
            wdata_reg  <= 32'h0000_0000;
            wstrb_reg  <= 4'h0;
        end else if (wvalid && wready_reg) begin
            wready_reg <= 1'b0;
            w_have_reg <= 1'b1;
            wdata_reg  <= wdata;
            wstrb_reg  <= wstrb;
        end else if (bvalid_reg && bready) begin
            wready_reg <= 1'b1;
            w_have_reg <= 1'b0;
        end
    end

    assign wr_fire = aw_have_reg & w_have_reg & ~bvalid_reg;

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= SEW_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= addr_ok(awaddr_reg) ? SEW_OKAY : SEW_SLVERR;
        end else if (bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Timeout enable control
    always_ff @(posedge aclk) begin
        if (!aresetn) ctrl_tmo_reg <= SEW_CTRL_RST;
        else if (wr_fire && awaddr_reg == SEW_A_CTRL && wstrb_reg[0])
            ctrl_tmo_reg <= wdata_reg[SEW_CTRL_TMO];
    end

    // Write one to clear flags
    assign sw_clr = (wr_fire && awaddr_reg == SEW_A_FLAGS && wstrb_reg[0])
                  ? wdata_reg[2:0] : 3'h0;

    // Read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
            rresp_reg   <= SEW_OKAY;
        end else if (arvalid && arready_reg) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rresp_reg   <= addr_ok(araddr) ? SEW_OKAY : SEW_SLVERR;
            unique case (araddr)
                SEW_A_CTRL:  rdata_reg <= 32'(ctrl_tmo_reg);
                SEW_A_FLAGS: rdata_reg <= 32'({stall_reg, flag_reg});
                SEW_A_TGT:   rdata_reg <= target_reg;
                default:     rdata_reg <= 32'h0000_0000;
            endcase
        end else if (rvalid_reg && rready) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
        end
    end

    assign awready = awready_reg;
    assign wready  = wready_reg;
    assign bvalid  = bvalid_reg;
    assign bresp   = bresp_reg;
    assign arready = arready_reg;
    assign rvalid  = rvalid_reg;
    assign rdata   = rdata_reg;
    assign rresp   = rresp_reg;

endmodule

/* File: verif/sew_streamer_model.sv */
// Behavioural streamer and system counter on the far side of the wait block
module sew_streamer_model
    import sew_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [2:0]  go,
    output logic             slot_ready,
    output logic             lut_rd,
    output logic [8:0]       lut_addr,
    output logic             osc_wrap,
    output logic [31:0]      sys_cnt
);
    timeunit 1ns;
    timeprecision 1ps;

    // Free running system counter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sys_cnt <= 32'h0000_0000;
        end else begin
            sys_cnt <= sys_cnt + 32'h0000_0001;
        end
    end

    // Events on request; lookup reads stay below the top location otherwise
    always_ff @(posedge aclk) begin
        slot_ready <= go[SEW_F_SLOT];
        lut_rd     <= 1'b1;
        lut_addr   <= go[SEW_F_LUT] ? SEW_LUT_LAST : {1'b0, sys_cnt[7:0]};
        osc_wrap   <= go[SEW_F_OSC];
    end
endmodule

/* File: verif/sew_core_test.sv */
// Self-checking bench for the streamer event wait block
module sew_core_test
    import sew_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========
    // Signals
    // ==========
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, stall, wait_done;
    logic        issue_valid, qload_valid, core_start, slot_ready, lut_rd, osc_wrap;
    logic [3:0]  awaddr, araddr, wstrb;
    logic [1:0]  bresp, rresp;
    logic [31:0] wdata, rdata, qload_value, sys_cnt;
    logic [8:0]  lut_addr;
    logic [2:0]  go, flags;
    sew_instr_t  issue_instr;
    sew_clr_t    clr_req;
    sew_fx_t     flag_fx;
    int          n_mismatch, checked, cyc;

    sew_core dut_u (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .issue_valid(issue_valid),
        .issue_instr(issue_instr), .qload_valid(qload_valid),
        .qload_value(qload_value), .clr_req(clr_req), .core_start(core_start),
        .slot_ready(slot_ready), .lut_rd(lut_rd), .lut_addr(lut_addr),
        .osc_wrap(osc_wrap), .sys_cnt(sys_cnt), .stall(stall),
        .wait_done(wait_done), .flag_fx(flag_fx), .flags(flags)
    );

    sew_streamer_model strm_u (
        .aclk(aclk), .aresetn(aresetn), .go(go), .slot_ready(slot_ready),
        .lut_rd(lut_rd), .lut_addr(lut_addr), .osc_wrap(osc_wrap), .sys_cnt(sys_cnt)
    );

    // Clock and hang guard
    always #2 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 8000) begin
            n_mismatch++;
            test_done();
        end
    end

    // ==========
    // Helpers
    // ==========
    task automatic test_done();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask

    // Bus write, address and data offered together
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    function automatic sew_instr_t wait_op(input int k, input logic c, input logic z);
        sew_instr_t w;
        w        = '0;
        w.cond   = 4'hF;
        w.opcode = SEW_OPC_EVT;
        w.c      = c;
        w.z      = z;
        w.src    = SEW_SRC_EVT;
        w.dest   = (k == 0) ? SEW_DST_SLOT : (k == 1) ? SEW_DST_LUT : SEW_DST_OSC;
        return w;
    endfunction

    // One issued instruction, released at the edge that takes it
    task automatic iss(input sew_instr_t ins, input logic ql, input logic [31:0] qv,
                       input sew_clr_t cl);
        @(posedge aclk);
        issue_valid <= 1'b1;
        issue_instr <= ins;
        qload_valid <= ql;
        qload_value <= qv;
        clr_req     <= cl;
        @(posedge aclk);
        issue_valid <= 1'b0;
        qload_valid <= 1'b0;
        clr_req     <= '0;
    endtask

    task automatic fire(input logic [2:0] m);
        @(posedge aclk);
        go <= m;
        @(posedge aclk);
        go <= 3'b000;
    endtask

    task automatic wait_end(output int n);
        n = 0;
        do begin
            @(posedge aclk);
            #1;
            n++;
        end while (wait_done !== 1'b1 && n < 600);
    endtask

    // ==========
    // Scenarios
    // ==========
    task automatic t_regs();
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(SEW_A_CTRL, d, r);
        chk("ctrl reset", 32'h0000_0001, d);
        axi_rd(SEW_A_FLAGS, d, r);
        chk("flags reset", 32'h0000_0000, d);
        axi_rd(4'hC, d, r);
        chk("unmapped read", 32'(SEW_SLVERR), 32'(r));
        axi_wr(SEW_A_TGT, 32'h1234_5678, r);
        chk("target write", 32'(SEW_OKAY), 32'(r));
        axi_wr(4'hC, 32'h0000_0001, r);
        chk("unmapped write", 32'(SEW_SLVERR), 32'(r));
        $display("test regs done");
    endtask

    task automatic t_fast();
        int n;
        for (int k = 0; k < 3; k++) begin
            fire(3'b001 << k);
            step(3);
            chk("flag set", 32'h0000_0001, 32'(flags[k]));
            iss(wait_op(k, 1'b1, 1'b1), 1'b0, 32'h0000_0000, '0);
            wait_end(n);
            chk("fast cycles", 32'h0000_0001, 32'(n));
            chk("fast fx", 32'h0000_0000, 32'(flag_fx));
            step(1);
            chk("fast clear", 32'h0000_0000, 32'(flags[k]));
        end
        $display("test fast done");
    endtask

    task automatic t_slow();
        int n;
        for (int k = 0; k < 3; k++) begin
            iss(wait_op(k, 1'b1, 1'b0), 1'b0, 32'h0000_0000, '0);
            fire(3'b111 & ~(3'b001 << k));
            step(3);
            iss('0, 1'b0, 32'h0000_0000, sew_clr_t'(4'hF));
            chk("stalled", 32'h0000_0001, 32'(stall));
            chk("held flags", 32'(3'b111 & ~(3'b001 << k)), 32'(flags));
            fire(3'b001 << k);
            wait_end(n);
            chk("event cycles", 32'h0000_0002, 32'(n));
            chk("plain fx", 32'h0000_0000, 32'(flag_fx));
            step(1);
            chk("event clear", 32'h0000_0000, 32'(flags[k]));
            iss('0, 1'b0, 32'h0000_0000, sew_clr_t'(4'hF));
        end
        $display("test slow done");
    endtask

    task automatic t_tmo();
        int          n;
        logic [31:0] t;
        logic [31:0] d;
        logic [1:0]  r;
        t = sys_cnt + 32'h0000_0028;
        iss('0, 1'b1, t, '0);
        iss(wait_op(2, 1'b1, 1'b1), 1'b0, 32'h0000_0000, '0);
        wait_end(n);
        chk("timeout fx", 32'h0000_000F, 32'(flag_fx));
        chk("timeout moment", t + 32'h0000_0001, sys_cnt);
        axi_rd(SEW_A_TGT, d, r);
        chk("target", t, d);
        t = sys_cnt + 32'h0000_00C8;
        iss('0, 1'b1, t, '0);
        iss(wait_op(1, 1'b1, 1'b0), 1'b0, 32'h0000_0000, '0);
        fire(3'b010);
        wait_end(n);
        chk("event fx", 32'h0000_0008, 32'(flag_fx));
        t = sys_cnt + 32'h0000_0014;
        iss('0, 1'b1, t, '0);
        iss('0, 1'b0, 32'h0000_0000, '0);
        iss(wait_op(0, 1'b1, 1'b1), 1'b0, 32'h0000_0000, '0);
        step(40);
        chk("no timeout", 32'h0000_0001, 32'(stall));
        fire(3'b001);
        wait_end(n);
        chk("disarmed fx", 32'h0000_0000, 32'(flag_fx));
        // Timeout enable off: a loaded target must not end the wait
        axi_wr(SEW_A_CTRL, 32'h0000_0000, r);
        axi_rd(SEW_A_CTRL, d, r);
        chk("ctrl off", 32'h0000_0000, d);
        t = sys_cnt + 32'h0000_0014;
        iss('0, 1'b1, t, '0);
        iss(wait_op(2, 1'b1, 1'b1), 1'b0, 32'h0000_0000, '0);
        step(40);
        chk("tmo off stall", 32'h0000_0001, 32'(stall));
        fire(3'b100);
        wait_end(n);
        chk("tmo off fx", 32'h0000_0000, 32'(flag_fx));
        axi_wr(SEW_A_CTRL, 32'h0000_0001, r);
        $display("test timeout done");
    endtask

    task automatic t_clear();
        logic [31:0] d;
        logic [1:0]  r;
        fire(3'b111);
        step(3);
        axi_rd(SEW_A_FLAGS, d, r);
        chk("flags reg", 32'h0000_0007, d);
        iss('0, 1'b0, 32'h0000_0000, sew_clr_t'(4'h8));
        step(1);
        chk("command clear", 32'h0000_0002, 32'(flags));
        @(posedge aclk);
        core_start <= 1'b1;
        @(posedge aclk);
        core_start <= 1'b0;
        step(1);
        chk("start clear", 32'h0000_0000, 32'(flags));
        for (int k = 0; k < 3; k++) begin
            fire(3'b111);
            step(3);
            iss('0, 1'b0, 32'h0000_0000, sew_clr_t'(4'h1 << k));
            step(1);
            chk("poll clear", 32'(3'b111 & ~(3'b001 << k)), 32'(flags));
            iss('0, 1'b0, 32'h0000_0000, sew_clr_t'(4'hF));
        end
        fire(3'b111);
        step(3);
        axi_wr(SEW_A_FLAGS, 32'h0000_0002, r);
        step(1);
        chk("soft clear", 32'h0000_0005, 32'(flags));
        $display("test clear done");
    endtask

    // Reset, then the scenarios in turn
    initial begin
        aclk        = 1'b0;
        aresetn     = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {issue_valid, qload_valid, core_start} = '0;
        {awaddr, araddr, wdata, qload_value} = '0;
        wstrb       = 4'hF;
        go          = 3'b000;
        issue_instr = '0;
        clr_req     = '0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_fast();
        t_slow();
        t_tmo();
        t_clear();
        test_done();
    end
endmodule
